//--- rbs_pkg.sv
// Notes on behaviour
// [RQ1] External reset pin asserted puts the device into hardware reset.
// [RQ2] In parallel host mode, the soft-reset bit in config_option_reg soft-resets.
// [RQ3] In USB mode, both data lines low over 2.5 us trigger USB reset.
// [RQ4] USB line reset clears only USB core, not a full soft reset.
// [RQ5] Hard and soft reset act alike, except the option and host config registers survive soft reset.
// [RQ6] Memory data pins 15:8 are sampled as straps during any reset.
// [RQ7] Straps read low unless pulled up; the board adds the pull-ups.
// [RQ8] Strap bits 15:14 give the serial memory kind code, default 0.
// [RQ9] Strap 13 set selects USB host; only attribute space stays enabled.
// [RQ10] Strap 12 set selects four-strobe SRAM, clear selects five-strobe.
// [RQ11] With boot ROM enabled, hardware ignores start-idle; firmware reads it.
// [RQ12] With boot ROM disabled and start-idle set, CPU waits for aux download.
// [RQ13] Strap 10 sets startup bus width: 16-bit when set, 8-bit clear.
// [RQ14] Board straps startup width to match the boot flash width.
// [RQ15] Strap 9 set maps control store to RAM, clear to NV space.
// [RQ16] Strap 9 only presets read-enable and map bits of option registers.
// [RQ17] Strap 8 set disables the internal boot ROM, clear enables it.
// [RQ18] Kind code 00 is a large firmware device; upper bit set unsupported.
// [RQ19] Kind code 01 is a small info-only device; controller then idles.
// [RQ20] Straps latch at reset release and hold until the next reset.
//
// package: register map, strap layout and timing counts
// assumes a 25 MHz pclk and a byte-addressed APB slave port

package rbs_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CONFIG_OPTION = 8'h00;
  localparam logic [7:0] OFS_HOST_CONFIG   = 8'h04;
  localparam logic [7:0] OFS_STRAP_STATUS  = 8'h08;
  localparam logic [7:0] OFS_RESET_STATUS  = 8'h0C;
  localparam logic [7:0] OFS_MEMORY_OPTION = 8'h10;
  localparam logic [7:0] OFS_CS_CONFIG     = 8'h14;

  // config_option_reg fields
  localparam int          COR_SRESET_BIT = 7;
  localparam logic [7:0]  COR_RESET      = 8'h00;
  localparam logic [7:0]  COR_WMASK      = 8'hBF;
  localparam logic [7:0]  HCR_RESET      = 8'h00;

  // reset_status sticky bits
  localparam int HW_SEEN_BIT  = 0;
  localparam int SW_SEEN_BIT  = 1;
  localparam int USB_SEEN_BIT = 2;
  localparam int RUN_BIT      = 3;

  // memory_option_reg / control_store_cfg_reg field positions
  localparam int NV_READ_ENABLE_BIT      = 0;
  localparam int MAP_LSB       = 1;
  localparam logic [1:0] MAP_TO_NV  = 2'h2;
  localparam logic [1:0] MAP_TO_RAM = 2'h1;

  // serial memory kind codes
  localparam logic [1:0] NV_KIND_LARGE = 2'h0;
  localparam logic [1:0] NV_KIND_CIS   = 2'h1;

  // strap defaults as seen with only the internal pull-downs
  localparam logic [7:0] STRAP_RESET = 8'h00;

  // timing: least time of sustained USB low, rounded up to cycles
  localparam real USB_LOW_US   = 2.5;
  localparam real PCLK_MHZ     = 25.0;
  localparam int  USB_LOW_CYC  = int'($ceil(USB_LOW_US * PCLK_MHZ));
  localparam int  SYNC_STAGES  = 3;

  // strap layout, msb first, matching pins 15 down to 8
  typedef struct packed {
    logic [1:0] serial_nv_kind;
    logic       serial_host_select;
    logic       sram_four_strobe_mode;
    logic       start_idle;
    logic       startup_wide_bus;
    logic       control_store_to_ram;
    logic       boot_rom_disable;
  } rbs_strap_type;

endpackage

//--- rbs_reset_strap.sv
// top: reset sources, strap capture and option preset registers
// assumes apb master on pclk; reset pin, usb lines and strap pins are async

`timescale 1ns/10ps

module rbs_reset_strap #(
  parameter int ADDR_W = 8
) (
  // clock and bus reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [ADDR_W-1:0]  paddr,
  input  wire logic [31:0]        pwdata,
  input  wire logic [3:0]         pstrb,
  output logic                    pready,
  output logic [31:0]             prdata,
  output logic                    pslverr,
  // pins
  input  wire logic               reset_pin_n,
  input  wire logic               usb_dp,
  input  wire logic               usb_dm,
  input  wire logic [7:0]         mem_data_strap_pins,
  input  wire logic               aux_download_done,
  // reset outputs
  output logic                    hardware_reset_state,
  output logic                    soft_reset_state,
  output logic                    device_reset_n,
  output logic                    usb_core_reset,
  output logic                    strap_pulldown_en,
  // configuration outputs
  output rbs_pkg::rbs_strap_type  strap,
  output logic                    pc_card_func_enable,
  output logic                    attribute_space_enable,
  output logic                    internal_boot_rom_enable,
  output logic                    nv_large_firmware,
  output logic                    nv_cis_only,
  output logic                    nv_unsupported,
  output logic                    boot_halt_after_load,
  output logic                    cpu_run_enable,
  output logic                    nv_read_enable,
  output logic [1:0]              store_map_bits
);

  localparam int CNT_W = $clog2(rbs_pkg::USB_LOW_CYC + 1);
  localparam logic [CNT_W-1:0] USB_CNT_MAX = CNT_W'(rbs_pkg::USB_LOW_CYC);

  // three-stage synchronisers; stage one feeds only stage two
  logic [10:0] sync1_reg;
  logic [10:0] sync2_reg;
  logic [10:0] sync3_reg;
  logic [10:0] pin_stable_reg;
  logic [10:0] pin_raw;

  assign pin_raw = {reset_pin_n, usb_dp, usb_dm, mem_data_strap_pins};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg      <= {8'h00, 3'h4};
      sync2_reg      <= {8'h00, 3'h4};
      sync3_reg      <= {8'h00, 3'h4};
      pin_stable_reg <= 11'h000;
    end else begin
      sync1_reg <= {pin_raw[10:8], pin_raw[7:0]};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      // a change counts only once the last two stages agree
      for (int i = 0; i < 11; i++) begin
        if (sync2_reg[i] == sync3_reg[i]) begin
          pin_stable_reg[i] <= sync3_reg[i];
        end
      end
    end
  end

  // named views of the filtered pins
  wire       pin_reset_n = pin_stable_reg[10];
  wire       pin_dp      = pin_stable_reg[9];
  wire       pin_dm      = pin_stable_reg[8];
  wire [7:0] pin_straps  = pin_stable_reg[7:0];

  // register state
  logic [7:0] cor_reg;
  logic [7:0] hcr_reg;
  logic [7:0] mor_reg;
  logic [7:0] control_store_cfg_reg_reg;
  logic [3:0] seen_reg;
  logic       aux_done_reg;
  logic [CNT_W-1:0] usb_cnt_reg;
  logic [CNT_W-1:0] usb_cnt_next;
  rbs_pkg::rbs_strap_type strap_reg;
  rbs_pkg::rbs_strap_type strap_pins;

  // reset source decode
  wire hw_reset   = ~pin_reset_n;                               // [RQ1]
  wire serial_sel = strap_reg.serial_host_select;
  wire sw_reset   = cor_reg[rbs_pkg::COR_SRESET_BIT] & ~serial_sel; // [RQ2]
  wire in_reset   = hw_reset | sw_reset;                         // [RQ5]
  wire usb_low    = serial_sel & ~pin_dp & ~pin_dm;

  assign hardware_reset_state = hw_reset;
  assign soft_reset_state     = sw_reset;
  assign device_reset_n       = ~in_reset;
  // weak pull-downs keep unstrapped pins low while sampled
  assign strap_pulldown_en    = in_reset;                        // [RQ7]
  assign strap_pins           = rbs_pkg::rbs_strap_type'(pin_straps);

  // straps follow the pins during reset and freeze at release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_reg <= rbs_pkg::rbs_strap_type'(rbs_pkg::STRAP_RESET);
    end else if (in_reset) begin
      strap_reg <= strap_pins;                                   // [RQ6] [RQ20]
    end
  end

  // strap decode
  assign strap                    = strap_reg;                   // [RQ8] [RQ10]
  assign pc_card_func_enable      = ~serial_sel;                 // [RQ9]
  assign attribute_space_enable   = 1'b1;                        // [RQ9]
  assign internal_boot_rom_enable = ~strap_reg.boot_rom_disable; // [RQ17]
  assign nv_large_firmware =
    (strap_reg.serial_nv_kind == rbs_pkg::NV_KIND_LARGE);        // [RQ18]
  assign nv_cis_only =
    (strap_reg.serial_nv_kind == rbs_pkg::NV_KIND_CIS);          // [RQ19]
  assign nv_unsupported = strap_reg.serial_nv_kind[1];           // [RQ18]
  // start-idle is only a firmware hint while the boot rom runs
  assign boot_halt_after_load =
    strap_reg.start_idle & ~strap_reg.boot_rom_disable;          // [RQ11]
  wire wait_for_aux = strap_reg.start_idle & strap_reg.boot_rom_disable;
  assign cpu_run_enable = ~in_reset & (~wait_for_aux | aux_done_reg); // [RQ12]

  // aux download completion, cleared by any reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_done_reg <= 1'b0;
    end else if (in_reset) begin
      aux_done_reg <= 1'b0;
    end else if (aux_download_done) begin
      aux_done_reg <= 1'b1;
    end
  end

  // consecutive low count; saturates at the threshold
  always_comb begin
    usb_cnt_next = '0;
    if (usb_low && usb_cnt_reg != USB_CNT_MAX) begin
      usb_cnt_next = usb_cnt_reg + CNT_W'(1);
    end else if (usb_low) begin
      usb_cnt_next = usb_cnt_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      usb_cnt_reg <= '0;
    end else begin
      usb_cnt_reg <= usb_cnt_next;                               // [RQ3]
    end
  end

  // only the usb core and the reset_status usb bit see this; straps and other registers are untouched
  assign usb_core_reset = (usb_cnt_reg == USB_CNT_MAX);          // [RQ3] [RQ4]

  // apb decode; one wait state so read data comes from a flop
  logic ack_reg;
  logic [31:0] prdata_reg;
  wire [7:0] addr8  = paddr[7:0];
  wire hit_cor  = (addr8 == rbs_pkg::OFS_CONFIG_OPTION);
  wire hit_hcr  = (addr8 == rbs_pkg::OFS_HOST_CONFIG);
  wire hit_strp = (addr8 == rbs_pkg::OFS_STRAP_STATUS);
  wire hit_rst  = (addr8 == rbs_pkg::OFS_RESET_STATUS);
  wire hit_mor  = (addr8 == rbs_pkg::OFS_MEMORY_OPTION);
  wire hit_control_store_cfg_reg = (addr8 == rbs_pkg::OFS_CS_CONFIG);
  wire hit_any  = hit_cor | hit_hcr | hit_strp | hit_rst | hit_mor | hit_control_store_cfg_reg;
  wire upper_zero = (paddr[ADDR_W-1:0] >> 8) == '0;
  wire mapped   = hit_any & upper_zero;
  wire do_write = psel & penable & ack_reg & pwrite & mapped & pstrb[0];
  wire do_read  = psel & penable & ~ack_reg & ~pwrite;
  wire [7:0] wbyte = pwdata[7:0];

  assign pready  = ack_reg;
  assign prdata  = prdata_reg;
  assign pslverr = ack_reg & ~mapped;

  // read mux
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (upper_zero) begin
      if (hit_cor)  rd_byte = cor_reg;
      if (hit_hcr)  rd_byte = hcr_reg;
      if (hit_strp) rd_byte = strap_reg;
      if (hit_rst)  rd_byte = {4'h0, seen_reg};
      if (hit_mor)  rd_byte = mor_reg;
      if (hit_control_store_cfg_reg) rd_byte = control_store_cfg_reg_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_reg    <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= psel & penable & ~ack_reg;
      if (do_read) begin
        prdata_reg <= {24'h000000, rd_byte};
      end
    end
  end

  // host registers survive a soft reset, cleared only by the pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cor_reg <= rbs_pkg::COR_RESET;
      hcr_reg <= rbs_pkg::HCR_RESET;
    end else if (hw_reset) begin
      cor_reg <= rbs_pkg::COR_RESET;                             // [RQ5]
      hcr_reg <= rbs_pkg::HCR_RESET;
    end else begin
      if (do_write && hit_cor) begin
        cor_reg <= wbyte & rbs_pkg::COR_WMASK;                   // [RQ2]
      end
      if (do_write && hit_hcr) begin
        hcr_reg <= wbyte;
      end
    end
  end

  // option presets come from the mapping strap during any reset
  wire       cs_ram_pin  = strap_pins.control_store_to_ram;
  wire [1:0] preset_map  = cs_ram_pin ? rbs_pkg::MAP_TO_RAM
                                      : rbs_pkg::MAP_TO_NV;
  wire [7:0] preset_opt  = {5'h00, preset_map, ~cs_ram_pin};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mor_reg  <= {5'h00, rbs_pkg::MAP_TO_NV, 1'b1};
      control_store_cfg_reg_reg <= {5'h00, rbs_pkg::MAP_TO_NV, 1'b1};
    end else if (in_reset) begin
      mor_reg  <= preset_opt;                                    // [RQ16]
      control_store_cfg_reg_reg <= preset_opt;                                    // [RQ15]
    end else begin
      if (do_write && hit_mor) begin
        mor_reg <= wbyte;
      end
      if (do_write && hit_control_store_cfg_reg) begin
        control_store_cfg_reg_reg <= wbyte;
      end
    end
  end

  assign nv_read_enable = mor_reg[rbs_pkg::NV_READ_ENABLE_BIT];
  assign store_map_bits = control_store_cfg_reg_reg[rbs_pkg::MAP_LSB +: 2];

  // sticky reset causes; a new event wins over a write-one clear
  logic [3:0] seen_set;
  logic [3:0] seen_clr;
  assign seen_set = {~in_reset, usb_core_reset, sw_reset, hw_reset};
  assign seen_clr = (do_write && hit_rst) ? wbyte[3:0] : 4'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_reg <= 4'h0;
    end else begin
      seen_reg <= (seen_reg & ~seen_clr) | seen_set;
    end
  end

  // checks

  property p_hw_pin;
    @(posedge pclk) disable iff (!presetn)
      $fell(reset_pin_n) ##0 (!reset_pin_n)[*5] |-> hardware_reset_state;
  endproperty
  a_hw_pin: assert property (p_hw_pin) else $error("pin reset missed"); // [RQ1]

  property p_soft;
    @(posedge pclk) disable iff (!presetn)
      cor_reg[7] && !strap_reg.serial_host_select |-> !device_reset_n;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset not held"); // [RQ2]

  property p_usb_time;
    @(posedge pclk) disable iff (!presetn)
      $rose(usb_core_reset) |-> $past(usb_low, 1) &&
        $past(usb_cnt_reg) == USB_CNT_MAX - CNT_W'(1);
  endproperty
  a_usb_time: assert property (p_usb_time) else $error("usb reset early"); // [RQ3]

  property p_usb_local;
    @(posedge pclk) disable iff (!presetn)
      usb_core_reset && !in_reset |=> $stable(strap_reg) && $stable(cor_reg);
  endproperty
  a_usb_local: assert property (p_usb_local) else $error("usb reset spread"); // [RQ4]

  property p_hw_clears;
    @(posedge pclk) disable iff (!presetn)
      hardware_reset_state |=> cor_reg == 8'h00 && hcr_reg == 8'h00;
  endproperty
  a_hw_clears: assert property (p_hw_clears) else $error("cor kept"); // [RQ5]

  property p_sample;
    @(posedge pclk) disable iff (!presetn)
      in_reset |=> strap_reg == $past(pin_straps);
  endproperty
  a_sample: assert property (p_sample) else $error("strap not sampled"); // [RQ6]

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
      !in_reset && !$past(in_reset) |-> $stable(strap_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("strap moved"); // [RQ20]

  property p_preset;
    @(posedge pclk) disable iff (!presetn)
      in_reset |=> nv_read_enable == !$past(pin_straps[1]);
  endproperty
  a_preset: assert property (p_preset) else $error("nv_read_enable preset"); // [RQ16]

  property p_aux_wait;
    @(posedge pclk) disable iff (!presetn)
      cpu_run_enable && strap_reg.start_idle && strap_reg.boot_rom_disable
        |-> aux_done_reg;
  endproperty
  a_aux_wait: assert property (p_aux_wait) else $error("ran early"); // [RQ12]

endmodule

//--- rbs_strap_board.sv
// partner: board strap resistors on the memory data pins 15:8
// assumes the device raises pulldown_en while it is in any reset

`timescale 1ns/10ps

module rbs_strap_board (
  // clock
  input  wire logic       pclk,
  // strap fitting
  input  wire logic       pulldown_en,
  input  wire logic [7:0] pullup_mask,
  // memory data pins 15:8
  output logic [7:0]      pins
);
  logic [7:0] traffic_reg = 8'h5A;

  // bus traffic after reset, so a stale strap sample cannot pass
  always_ff @(posedge pclk) traffic_reg <= traffic_reg + 8'h3B;

  // unfitted bits fall to the weak pull-down; width strap set by fitting
  assign pins = pulldown_en ? pullup_mask : traffic_reg;
endmodule

//--- reset_and_boot_strap_capture_tb.sv
// testbench: reset sources, strap capture and derived configuration
// assumes rbs_reset_strap with its apb port and the strap board model

`timescale 1ns/10ps

module reset_and_boot_strap_capture_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, mask, mem_data_strap_pins;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic        reset_pin_n, usb_dp, usb_dm, aux_download_done, err;
  logic        hardware_reset_state, soft_reset_state, device_reset_n;
  logic        usb_core_reset, strap_pulldown_en, pc_card_func_enable;
  logic        attribute_space_enable, internal_boot_rom_enable;
  logic        nv_large_firmware, nv_cis_only, nv_unsupported;
  logic        boot_halt_after_load, cpu_run_enable, nv_read_enable;
  logic [1:0]  store_map_bits;
  rbs_pkg::rbs_strap_type strap;
  int          miscompares = 0;
  int          compares = 0;
  logic [7:0]  tab [4] = '{8'h11, 8'hEE, 8'h4A, 8'hB5};

  rbs_reset_strap i_dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr, .reset_pin_n,
    .usb_dp, .usb_dm, .mem_data_strap_pins, .aux_download_done,
    .hardware_reset_state, .soft_reset_state, .device_reset_n,
    .usb_core_reset, .strap_pulldown_en, .strap, .pc_card_func_enable,
    .attribute_space_enable, .internal_boot_rom_enable,
    .nv_large_firmware, .nv_cis_only, .nv_unsupported,
    .boot_halt_after_load, .cpu_run_enable, .nv_read_enable,
    .store_map_bits);

  rbs_strap_board i_board (.pclk(pclk), .pulldown_en(strap_pulldown_en),
    .pullup_mask(mask), .pins(mem_data_strap_pins));

  // 25 MHz clock
  always #20 pclk = ~pclk;

  task stop_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task chk_bit(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask

  task chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one apb transfer; pready is looked at where settled, before its edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk) begin
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    end
    @(posedge pclk) penable <= 1'b1;
    n = 0;
    @(negedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(negedge pclk);
      n++;
    end
    rd = prdata;
    err = pslverr;
    @(posedge pclk) begin psel <= 1'b0; penable <= 1'b0; end
    if (n >= 50) miscompares++;
  endtask

  // pin reset with a strap fitting, then capture and decode checks
  task hw_cap(input logic [7:0] m);
    int n;
    @(posedge pclk) begin mask <= m; reset_pin_n <= 1'b0; end
    repeat (8) @(posedge pclk);
    #1;
    chk_bit("hw_reset", 1'b1, hardware_reset_state);
    chk_bit("dev_rst_n", 1'b0, device_reset_n);
    @(posedge pclk) reset_pin_n <= 1'b1;
    n = 0;
    while (device_reset_n !== 1'b1 && n < 20) begin
      @(posedge pclk);
      #1;
      n++;
    end
    repeat (20) @(posedge pclk);
    #1;
    chk_word("strap", {24'h0, m}, {24'h0, strap});
    chk_bit("large", m[7:6] == 2'h0, nv_large_firmware);
    chk_bit("cis", m[7:6] == 2'h1, nv_cis_only);
    chk_bit("unsup", m[7], nv_unsupported);
    chk_bit("pc_card", !m[5], pc_card_func_enable);
    chk_bit("attr", 1'b1, attribute_space_enable);
    chk_bit("rom_en", !m[0], internal_boot_rom_enable);
    chk_bit("halt", m[3] & !m[0], boot_halt_after_load);
    chk_bit("run", !(m[3] & m[0]), cpu_run_enable);
    chk_bit("nv_read_enable", !m[1], nv_read_enable);
    chk_word("map", m[1] ? 32'h1 : 32'h2, {30'h0, store_map_bits});
    apb(1'b0, rbs_pkg::OFS_STRAP_STATUS, 32'h0);
    chk_word("strap_reg", {24'h0, m}, rd);
  endtask

  // soft reset from the parallel host; config option and host config registers survive it
  task soft_case;
    hw_cap(8'h11);
    apb(1'b1, rbs_pkg::OFS_HOST_CONFIG, 32'h3C);
    apb(1'b1, rbs_pkg::OFS_CONFIG_OPTION, 32'h81);
    @(posedge pclk) mask <= 8'h14;
    repeat (8) @(posedge pclk);
    #1;
    chk_bit("sw_reset", 1'b1, soft_reset_state);
    chk_bit("dev_rst_n", 1'b0, device_reset_n);
    chk_bit("hw_reset", 1'b0, hardware_reset_state);
    apb(1'b1, rbs_pkg::OFS_CONFIG_OPTION, 32'h01);
    repeat (20) @(posedge pclk);
    #1;
    chk_word("strap", 32'h14, {24'h0, strap});
    chk_bit("nv_read_enable", 1'b1, nv_read_enable);
    apb(1'b0, rbs_pkg::OFS_HOST_CONFIG, 32'h0);
    chk_word("hcr", 32'h3C, rd);
    apb(1'b0, rbs_pkg::OFS_CONFIG_OPTION, 32'h0);
    chk_word("cor", 32'h01, rd);
    apb(1'b0, 8'h40, 32'h0);
    chk_bit("unmapped", 1'b1, err);
  endtask

  // usb line reset: 62 low cycles too short, a long one resets usb only
  task usb_case;
    int n;
    hw_cap(8'h31);
    apb(1'b1, rbs_pkg::OFS_CONFIG_OPTION, 32'h80);
    #1;
    chk_bit("sw_in_usb", 1'b0, soft_reset_state);
    apb(1'b1, rbs_pkg::OFS_CONFIG_OPTION, 32'h00);
    n = 0;
    @(posedge pclk) begin usb_dp <= 1'b0; usb_dm <= 1'b0; end
    repeat (61) begin
      @(posedge pclk);
      #1;
      if (usb_core_reset !== 1'b0) n++;
    end
    @(posedge pclk) usb_dp <= 1'b1;
    repeat (8) begin
      @(posedge pclk);
      #1;
      if (usb_core_reset !== 1'b0) n++;
    end
    chk_bit("usb_short", 1'b0, n != 0);
    @(posedge pclk) usb_dp <= 1'b0;
    repeat (75) @(posedge pclk);
    #1;
    chk_bit("usb_long", 1'b1, usb_core_reset);
    chk_bit("dev_rst_n", 1'b1, device_reset_n);
    chk_word("strap", 32'h31, {24'h0, strap});
    @(posedge pclk) usb_dp <= 1'b1;
    repeat (8) @(posedge pclk);
    #1;
    chk_bit("usb_end", 1'b0, usb_core_reset);
  endtask

  // start idle with boot rom off waits for the auxiliary download
  task aux_case;
    hw_cap(8'h09);
    @(posedge pclk) aux_download_done <= 1'b1;
    @(posedge pclk) aux_download_done <= 1'b0;
    repeat (3) @(posedge pclk);
    #1;
    chk_bit("run_aux", 1'b1, cpu_run_enable);
  endtask

  // main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hF;
    reset_pin_n = 1'b1;
    usb_dp = 1'b1;
    usb_dm = 1'b0;
    aux_download_done = 1'b0;
    mask = 8'h11;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    foreach (tab[i]) hw_cap(tab[i]);
    soft_case;
    usb_case;
    aux_case;
    stop_test;
  end

  // watchdog well beyond the roughly 500 cycles of the run
  initial begin
    repeat (5000) @(posedge pclk);
    miscompares++;
    stop_test;
  end
endmodule
